// [hw/aot_pkg.sv]
// Purpose: constants and carrier types for the converter output test and config block
// Assumes: 11-bit sample path, 8-bit serial-port registers
// Notes:   single clock domain, serial port pins synchronised inside the top
package aot_pkg;
  localparam int SAMPLE_W = 11;
  localparam int ADDR_W   = 13;
  localparam int SPI_BITS = 24;

  // serial frame layout: 16-bit instruction then one data byte, msb first
  localparam logic [4:0] SPI_LAST_INSTR = 5'h0f;
  localparam logic [4:0] SPI_LAST_BIT   = 5'h17;
  localparam int         SPI_RW_BIT     = 15;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CLK_DIV   = 13'h000b;
  localparam logic [ADDR_W-1:0] OFS_TEST_SEL  = 13'h000d;
  localparam logic [ADDR_W-1:0] OFS_OFS_TRIM  = 13'h0010;
  localparam logic [ADDR_W-1:0] OFS_OUT_FMT   = 13'h0014;
  localparam logic [ADDR_W-1:0] OFS_DRIVE     = 13'h0015;
  localparam logic [ADDR_W-1:0] OFS_CLK_POL   = 13'h0016;
  localparam logic [ADDR_W-1:0] OFS_CLK_DLY   = 13'h0017;
  localparam logic [ADDR_W-1:0] OFS_SPAN      = 13'h0018;
  localparam logic [ADDR_W-1:0] OFS_USER1_LO  = 13'h0019;

  // writable bit masks, open bits read as zero
  localparam logic [7:0] MSK_CLK_DIV  = 8'h3f;
  localparam logic [7:0] MSK_TEST_SEL = 8'hbf;
  localparam logic [7:0] MSK_OFS_TRIM = 8'h3f;
  localparam logic [7:0] MSK_OUT_FMT  = 8'h17;
  localparam logic [7:0] MSK_DRIVE    = 8'h0f;
  localparam logic [7:0] MSK_CLK_POL  = 8'h80;
  localparam logic [7:0] MSK_CLK_DLY  = 8'h87;
  localparam logic [7:0] MSK_SPAN     = 8'h1f;
  localparam logic [7:0] MSK_USER1_LO = 8'hff;

  // reset values
  localparam logic [7:0] RST_OUT_FMT = 8'h01;
  localparam logic [7:0] RST_DRIVE   = 8'h01;
  localparam logic [7:0] RST_ZERO    = 8'h00;

  // field positions
  localparam int DIV_RATIO_LSB = 0;
  localparam int DIV_RATIO_W   = 3;
  localparam int TEST_MODE_LSB = 0;
  localparam int TEST_MODE_W   = 4;
  localparam int PN_SHORT_RST  = 4;
  localparam int PN_LONG_RST   = 5;
  localparam int USER_SINGLE   = 7;
  localparam int FMT_LSB       = 0;
  localparam int FMT_W         = 2;
  localparam int INVERT_BIT    = 2;
  localparam int OUT_DIS_BIT   = 4;
  localparam int CLK_INV_BIT   = 7;

  // test selection codes
  localparam logic [3:0] TM_OFF     = 4'h0;
  localparam logic [3:0] TM_MID     = 4'h1;
  localparam logic [3:0] TM_POS_FS  = 4'h2;
  localparam logic [3:0] TM_NEG_FS  = 4'h3;
  localparam logic [3:0] TM_CHECKER = 4'h4;
  localparam logic [3:0] TM_PN_LONG = 4'h5;
  localparam logic [3:0] TM_PN_SHRT = 4'h6;
  localparam logic [3:0] TM_TOGGLE  = 4'h7;
  localparam logic [3:0] TM_USER    = 4'h8;
  localparam logic [3:0] TM_RAMP    = 4'hf;

  // output formats
  localparam logic [1:0] FMT_OFFSET = 2'h0;
  localparam logic [1:0] FMT_TWOS   = 2'h1;
  localparam logic [1:0] FMT_GRAY   = 2'h2;

  // fixed pattern words
  localparam logic [SAMPLE_W-1:0] PAT_MID   = 11'h400;
  localparam logic [SAMPLE_W-1:0] PAT_POS   = 11'h7ff;
  localparam logic [SAMPLE_W-1:0] PAT_NEG   = 11'h000;
  localparam logic [SAMPLE_W-1:0] PAT_CHK_A = 11'h555;
  localparam logic [SAMPLE_W-1:0] PAT_CHK_B = 11'h2aa;
  localparam logic [22:0]         PN_LONG_SEED  = 23'h7fffff;
  localparam logic [8:0]          PN_SHORT_SEED = 9'h1ff;

  // software-visible configuration
  typedef struct packed {
    logic [7:0] clk_div;
    logic [7:0] test_sel;
    logic [7:0] ofs_trim;
    logic [7:0] out_fmt;
    logic [7:0] drive;
    logic [7:0] clk_pol;
    logic [7:0] clk_dly;
    logic [7:0] span;
    logic [7:0] user1_lo;
  } aot_cfg_t;

  // controls handed to the pattern generator
  typedef struct packed {
    logic [3:0] mode;
    logic       single_shot;
    logic       pn_long_rst;
    logic       pn_short_rst;
    logic [7:0] user_byte;
  } aot_pat_ctl_t;
endpackage

// [hw/aot_pattern_gen.sv]
// Purpose: test word generator, one new word per divided sample tick
// Assumes: tick is a one-cycle pulse at the divided rate
// Notes:   word comes from a register, so it lags the selection by one tick
`timescale 1ns/1ns
module aot_pattern_gen
  import aot_pkg::*;
(
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // control
  input  wire logic                       tick,
  input  wire aot_pkg::aot_pat_ctl_t      ctl,
  // pattern out
  output logic [aot_pkg::SAMPLE_W-1:0]    word_reg
);
  logic [22:0]          pn_long_reg;
  logic [8:0]           pn_short_reg;
  logic [SAMPLE_W-1:0]  ramp_reg;
  logic                 phase_reg;
  logic                 sent_reg;
  logic [SAMPLE_W-1:0]  word_next;
  logic [SAMPLE_W-1:0]  user_word;
  logic                 is_user;

  assign is_user   = (ctl.mode == TM_USER);
  // only the low byte of the first user word is held here
  assign user_word = {3'h0, ctl.user_byte};

  always_comb begin
    case (ctl.mode)
      TM_MID:     word_next = PAT_MID;
      TM_POS_FS:  word_next = PAT_POS;
      TM_NEG_FS:  word_next = PAT_NEG;
      TM_CHECKER: word_next = phase_reg ? PAT_CHK_B : PAT_CHK_A;
      TM_PN_LONG: word_next = pn_long_reg[SAMPLE_W-1:0];
      TM_PN_SHRT: word_next = {2'h0, pn_short_reg};
      TM_TOGGLE:  word_next = phase_reg ? PAT_NEG : PAT_POS;
      TM_USER:    word_next = (ctl.single_shot && sent_reg) ? PAT_NEG : user_word;
      TM_RAMP:    word_next = ramp_reg;
      default:    word_next = PAT_NEG;
    endcase
  end

  // generator state advances only on the sample tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      word_reg     <= PAT_NEG;
      pn_long_reg  <= PN_LONG_SEED;
      pn_short_reg <= PN_SHORT_SEED;
      ramp_reg     <= PAT_NEG;
      phase_reg    <= 1'b0;
      sent_reg     <= 1'b0;
    end else if (tick) begin
      word_reg     <= word_next;
      pn_long_reg  <= ctl.pn_long_rst  ? PN_LONG_SEED :
                      {pn_long_reg[21:0], pn_long_reg[22] ^ pn_long_reg[17]};
      pn_short_reg <= ctl.pn_short_rst ? PN_SHORT_SEED :
                      {pn_short_reg[7:0], pn_short_reg[8] ^ pn_short_reg[4]};
      ramp_reg     <= ramp_reg + 11'h001;
      phase_reg    <= ~phase_reg;
      // leaving user mode rearms the single shot
      sent_reg     <= is_user;
    end
  end

  AST_POS_FS: assert property (@(posedge clk) disable iff (!rstn)
    tick && ctl.mode == TM_POS_FS |=> word_reg == 11'h7ff)
    else $error("positive full scale word wrong");

  AST_SINGLE_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    tick && is_user && ctl.single_shot && sent_reg |=> word_reg == 11'h000)
    else $error("single-shot user pattern did not fall to zero");

  AST_REPEAT: assert property (@(posedge clk) disable iff (!rstn)
    tick && is_user && !ctl.single_shot |=> word_reg == {3'h0, $past(ctl.user_byte)})
    else $error("repeat user pattern not sent");
endmodule

// [hw/aot_top.sv]
// Purpose: clock divider, test patterns, format and invert for converter output words
// Assumes: samples arrive offset binary on clk; serial port is 3-wire, msb first
// Notes:   one data byte per frame, writes take effect at frame end
// Summary of operation
// - input clock divided by divide-ratio field plus one
// - four-bit test selection decodes to nine pattern kinds, ramp at all ones
// - any selection other than off replaces converted samples with test words
// - user pattern repeats when control bit low, else sent once then zeros
// - invert bit high inverts output words; resets low
`timescale 1ns/1ns
module aot_top
  import aot_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // converter samples
  input  wire logic [aot_pkg::SAMPLE_W-1:0] sample_in,
  // serial control port
  input  wire logic                      spi_csb_n,
  input  wire logic                      spi_sclk,
  input  wire logic                      spi_sdio_in,
  output logic                           spi_sdio_out,
  output logic                           spi_sdio_oe,
  // parallel output
  output logic [aot_pkg::SAMPLE_W-1:0]   data_out_reg,
  output logic                           data_oe_reg,
  output logic                           output_data_clock
);
  aot_cfg_t             cfg_reg;
  logic [2:0]           csb_sync;
  logic [2:0]           sclk_sync;
  logic [2:0]           sdio_sync;
  logic [SPI_BITS-1:0]  shift_reg;
  logic [4:0]           bit_cnt_reg;
  logic [7:0]           rd_shift_reg;
  logic                 rd_frame_reg;
  logic                 sdo_reg;
  logic                 sdo_oe_reg;
  logic [2:0]           div_cnt_reg;
  logic                 dclk_reg;
  logic [2:0]           gap_reg;

  logic                 sel_n;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic [SPI_BITS-1:0]  shift_next;
  logic                 instr_done;
  logic                 frame_done;
  logic                 wr_commit;
  logic [ADDR_W-1:0]    frame_addr;
  logic [7:0]           rd_data;
  logic [2:0]           ratio;
  logic                 tick;
  logic [2:0]           half;
  logic                 test_active;
  logic                 invert;
  logic [SAMPLE_W-1:0]  pat_word;
  logic [SAMPLE_W-1:0]  fmt_word;
  logic [SAMPLE_W-1:0]  sel_word;
  aot_pat_ctl_t         pat_ctl;

  // offset binary in, chosen code out; reserved code passes unchanged
  function automatic logic [SAMPLE_W-1:0] encode(input logic [SAMPLE_W-1:0] s,
                                                 input logic [1:0] f);
    case (f)
      FMT_TWOS: encode = {~s[SAMPLE_W-1], s[SAMPLE_W-2:0]};
      FMT_GRAY: encode = s ^ (s >> 1);
      default:  encode = s;
    endcase
  endfunction

  // three-stage pin synchronisers; stage one feeds only stage two
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      csb_sync  <= 3'h7;
      sclk_sync <= 3'h0;
      sdio_sync <= 3'h0;
    end else begin
      csb_sync  <= {csb_sync[1:0], spi_csb_n};
      sclk_sync <= {sclk_sync[1:0], spi_sclk};
      sdio_sync <= {sdio_sync[1:0], spi_sdio_in};
    end
  end

  // edge and frame decode from stages two and three only
  assign sel_n      = csb_sync[2];
  assign sclk_rise  = !sel_n && sclk_sync[1] && !sclk_sync[2];
  assign sclk_fall  = !sel_n && !sclk_sync[1] && sclk_sync[2];
  assign shift_next = {shift_reg[SPI_BITS-2:0], sdio_sync[2]};
  assign instr_done = sclk_rise && bit_cnt_reg == SPI_LAST_INSTR;
  assign frame_done = sclk_rise && bit_cnt_reg == SPI_LAST_BIT;
  // at the last rise the frame is only whole in shift_next, not yet in shift_reg
  assign wr_commit  = frame_done && !shift_next[SPI_BITS-1];
  assign frame_addr = instr_done ? shift_next[ADDR_W-1:0] : shift_next[ADDR_W+7:8];

  // register read mux, open bits zero
  always_comb begin
    case (frame_addr)
      OFS_CLK_DIV:  rd_data = cfg_reg.clk_div;
      OFS_TEST_SEL: rd_data = cfg_reg.test_sel;
      OFS_OFS_TRIM: rd_data = cfg_reg.ofs_trim;
      OFS_OUT_FMT:  rd_data = cfg_reg.out_fmt;
      OFS_DRIVE:    rd_data = cfg_reg.drive;
      OFS_CLK_POL:  rd_data = cfg_reg.clk_pol;
      OFS_CLK_DLY:  rd_data = cfg_reg.clk_dly;
      OFS_SPAN:     rd_data = cfg_reg.span;
      OFS_USER1_LO: rd_data = cfg_reg.user1_lo;
      default:      rd_data = RST_ZERO;
    endcase
  end

  // serial frame engine; reads launch on falling sclk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg    <= '0;
      bit_cnt_reg  <= 5'h00;
      rd_shift_reg <= RST_ZERO;
      rd_frame_reg <= 1'b0;
      sdo_reg      <= 1'b0;
      sdo_oe_reg   <= 1'b0;
    end else if (sel_n) begin
      bit_cnt_reg  <= 5'h00;
      rd_frame_reg <= 1'b0;
      sdo_oe_reg   <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shift_reg   <= shift_next;
        bit_cnt_reg <= frame_done ? 5'h00 : bit_cnt_reg + 5'h01;
      end
      if (instr_done) begin
        rd_frame_reg <= shift_next[SPI_RW_BIT];
        rd_shift_reg <= rd_data;
      end
      if (sclk_fall && rd_frame_reg) begin
        sdo_reg      <= rd_shift_reg[7];
        sdo_oe_reg   <= 1'b1;
        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
      end
      if (frame_done) begin
        rd_frame_reg <= 1'b0;
      end
    end
  end
  assign spi_sdio_out = sdo_reg;
  assign spi_sdio_oe  = sdo_oe_reg;

  // register writes, user byte resets zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg          <= '0;
      cfg_reg.out_fmt  <= RST_OUT_FMT;
      cfg_reg.drive    <= RST_DRIVE;
    end else if (wr_commit) begin
      case (frame_addr)
        OFS_CLK_DIV:  cfg_reg.clk_div  <= shift_next[7:0] & MSK_CLK_DIV;
        OFS_TEST_SEL: cfg_reg.test_sel <= shift_next[7:0] & MSK_TEST_SEL;
        OFS_OFS_TRIM: cfg_reg.ofs_trim <= shift_next[7:0] & MSK_OFS_TRIM;
        OFS_OUT_FMT:  cfg_reg.out_fmt  <= shift_next[7:0] & MSK_OUT_FMT;
        OFS_DRIVE:    cfg_reg.drive    <= shift_next[7:0] & MSK_DRIVE;
        OFS_CLK_POL:  cfg_reg.clk_pol  <= shift_next[7:0] & MSK_CLK_POL;
        OFS_CLK_DLY:  cfg_reg.clk_dly  <= shift_next[7:0] & MSK_CLK_DLY;
        OFS_SPAN:     cfg_reg.span     <= shift_next[7:0] & MSK_SPAN;
        OFS_USER1_LO: cfg_reg.user1_lo <= shift_next[7:0] & MSK_USER1_LO;
        default:      cfg_reg          <= cfg_reg;
      endcase
    end
  end

  assign ratio = cfg_reg.clk_div[DIV_RATIO_LSB +: DIV_RATIO_W];
  assign tick  = (div_cnt_reg >= ratio);
  // clock high for the first half; divide by one leaves it steady
  assign half  = 3'((4'(ratio) + 4'h2) >> 1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 3'h0;
      dclk_reg    <= 1'b0;
    end else begin
      div_cnt_reg <= tick ? 3'h0 : div_cnt_reg + 3'h1;
      dclk_reg    <= ((tick ? 3'h0 : div_cnt_reg + 3'h1) < half) ^ cfg_reg.clk_pol[CLK_INV_BIT];
    end
  end
  assign output_data_clock = dclk_reg;

  // pattern controls
  assign pat_ctl.mode         = cfg_reg.test_sel[TEST_MODE_LSB +: TEST_MODE_W];
  assign pat_ctl.single_shot  = cfg_reg.test_sel[USER_SINGLE];
  assign pat_ctl.pn_long_rst  = cfg_reg.test_sel[PN_LONG_RST];
  assign pat_ctl.pn_short_rst = cfg_reg.test_sel[PN_SHORT_RST];
  assign pat_ctl.user_byte    = cfg_reg.user1_lo;

  aot_pattern_gen u_pat (
    .clk      (clk),
    .rstn     (rstn),
    .tick     (tick),
    .ctl      (pat_ctl),
    .word_reg (pat_word)
  );

  assign test_active = (pat_ctl.mode != TM_OFF);
  assign fmt_word    = encode(sample_in, cfg_reg.out_fmt[FMT_LSB +: FMT_W]);
  assign sel_word    = test_active ? pat_word : fmt_word;
  assign invert      = cfg_reg.out_fmt[INVERT_BIT];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_out_reg <= '0;
      data_oe_reg  <= 1'b0;
    end else begin
      data_oe_reg <= !cfg_reg.out_fmt[OUT_DIS_BIT];
      if (tick) begin
        data_out_reg <= invert ? ~sel_word : sel_word;
      end
    end
  end

  // helper: cycles since last tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= 3'h0;
    end else begin
      gap_reg <= tick ? 3'h0 : gap_reg + 3'h1;
    end
  end

  AST_DIV_PERIOD: assert property (@(posedge clk) disable iff (!rstn)
    tick && $past(tick) == 1'b0 && $stable(ratio) && gap_reg != 3'h0 |-> gap_reg == ratio)
    else $error("sample tick spacing differs from divide ratio");

  AST_REPLACE: assert property (@(posedge clk) disable iff (!rstn)
    tick && test_active && !invert |=> data_out_reg == $past(pat_word))
    else $error("test word did not replace sample");

  AST_INVERT: assert property (@(posedge clk) disable iff (!rstn)
    tick && invert |=> data_out_reg == ~$past(sel_word))
    else $error("inverted output word wrong");

  AST_USER_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_commit && frame_addr == OFS_USER1_LO) |=> $stable(cfg_reg.user1_lo))
    else $error("user byte changed without a write");

  AST_GRAY: assert property (@(posedge clk) disable iff (!rstn)
    tick && !test_active && !invert && cfg_reg.out_fmt[1:0] == 2'h2
    |=> data_out_reg == ($past(sample_in) ^ ($past(sample_in) >> 1)))
    else $error("gray coded output wrong");

  AST_TWOS: assert property (@(posedge clk) disable iff (!rstn)
    tick && !test_active && !invert && cfg_reg.out_fmt[1:0] == 2'h1
    |=> data_out_reg[10] == !$past(sample_in[10]))
    else $error("twos complement sign wrong");
endmodule

// [testbench/aot_capture.sv]
// Purpose: downstream capture model for the parallel output words
// Assumes: one word taken at each rise of output_data_clock, seen on clk
// Notes:   reports clock period in clk cycles and counts words equal to watch
`timescale 1ns/1ns
module aot_capture
  import aot_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // from the block
  input  wire logic [aot_pkg::SAMPLE_W-1:0] word,
  input  wire logic                         dclk,
  // bench control and results
  input  wire logic [aot_pkg::SAMPLE_W-1:0] watch,
  input  wire logic                         clr,
  output logic [7:0]                        period_reg,
  output logic [7:0]                        hits_reg
);
  logic       prev_reg;
  logic [7:0] cnt_reg;
  wire        rise = dclk && !prev_reg;

  // sampling on clk, not dclk: a divide by one clock never toggles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_reg   <= 1'b0;
      cnt_reg    <= 8'h00;
      period_reg <= 8'h00;
      hits_reg   <= 8'h00;
    end else begin
      prev_reg <= dclk;
      cnt_reg  <= rise ? 8'h01 : cnt_reg + 8'h01;
      if (rise) begin
        period_reg <= cnt_reg;
        hits_reg   <= clr ? 8'h00 : hits_reg + {7'h00, word == watch};
      end else if (clr) begin
        hits_reg <= 8'h00;
      end
    end
  end
endmodule

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the output test and config block
// Assumes: serial port driven slowly, each sclk level six clk cycles
// Notes:   inputs change at the falling clk edge only
`timescale 1ns/1ns
module tb_top;
  import aot_pkg::*;
  logic                clk;
  logic                rstn;
  logic                csb_n;
  logic                sclk;
  logic                sdi;
  logic                clr;
  logic [SAMPLE_W-1:0] smp;
  logic [SAMPLE_W-1:0] watch;
  logic                sdo;
  logic                sdo_oe;
  logic [SAMPLE_W-1:0] dout;
  logic                doe;
  logic                dclk;
  logic [7:0]          period;
  logic [7:0]          hits;
  logic                oe_mid;
  int                  n_fail;
  int                  tests_run;
  int                  cyc;
  localparam logic [12:0] ADR [9] = '{13'h00b, 13'h00d, 13'h010, 13'h014, 13'h015,
                                      13'h016, 13'h017, 13'h018, 13'h019};
  localparam logic [7:0]  MSK [9] = '{8'h3f, 8'hbf, 8'h3f, 8'h17, 8'h0f,
                                      8'h80, 8'h87, 8'h1f, 8'hff};
  localparam logic [7:0]  RST [9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
                                      8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0]  PM [7]  = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0e, 8'h25, 8'h16};
  localparam logic [10:0] PE [7]  = '{11'h400, 11'h7ff, 11'h000, 11'h000, 11'h000,
                                      11'h7ff, 11'h1ff};
  localparam logic [7:0]  FV [5]  = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04};
  localparam logic [10:0] FE [5]  = '{11'h123, 11'h523, 11'h1b2, 11'h123, 11'h6dc};

  aot_top DUT (.clk(clk), .rstn(rstn), .sample_in(smp), .spi_csb_n(csb_n),
    .spi_sclk(sclk), .spi_sdio_in(sdi), .spi_sdio_out(sdo), .spi_sdio_oe(sdo_oe),
    .data_out_reg(dout), .data_oe_reg(doe), .output_data_clock(dclk));
  aot_capture u_cap (.clk(clk), .rstn(rstn), .word(dout), .dclk(dclk),
    .watch(watch), .clr(clr), .period_reg(period), .hits_reg(hits));

  // free-running clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one 24-bit frame; read bits sampled at the end of each low phase
  task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [23:0] f;
    f = {rd, 2'b00, a, d};
    q = 8'h00;
    oe_mid = 1'b0;
    csb_n = 1'b0;
    repeat (6) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      sdi  = f[i];
      sclk = 1'b0;
      repeat (6) @(negedge clk);
      if (i < 8) q[i] = sdo;
      if (i == 0) oe_mid = sdo_oe;
      sclk = 1'b1;
      repeat (6) @(negedge clk);
    end
    sclk = 1'b0;
    repeat (6) @(negedge clk);
    csb_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask

  task automatic rdchk(input string nm, input logic [12:0] a, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    cmp(nm, {8'h00, e}, {8'h00, q});
    cmp("read drive on", 16'h0001, {15'h0000, oe_mid});
    cmp("read drive off", 16'h0000, {15'h0000, sdo_oe});
  endtask

  // reset values, writable bits, unmapped place
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      rdchk("reset value", ADR[i], RST[i]);
      wr(ADR[i], 8'hff);
      rdchk("writable bits", ADR[i], MSK[i]);
      wr(ADR[i], RST[i]);
    end
    wr(13'h030, 8'hff);
    rdchk("unmapped", 13'h030, 8'h00);
    $display("done t_regs");
  endtask

  // period of the output clock for every ratio above one
  task automatic t_div();
    // divide by one: clock stands still, polarity bit flips its level
    cmp("steady clock", 16'h0001, {15'h0000, dclk});
    wr(13'h016, 8'h80);
    cmp("inverted steady clock", 16'h0000, {15'h0000, dclk});
    wr(13'h016, 8'h00);
    for (int r = 1; r < 8; r++) begin
      wr(13'h00b, r[7:0]);
      repeat (30) @(negedge clk);
      cmp("clock period", 16'(r + 1), {8'h00, period});
    end
    wr(13'h00b, 8'h01);
    $display("done t_div");
  endtask

  // formats on converted samples, invert on both, output enable
  task automatic t_fmt();
    for (int i = 0; i < 5; i++) begin
      wr(13'h014, FV[i]);
      repeat (10) @(negedge clk);
      cmp("formatted word", {5'h00, FE[i]}, {5'h00, dout});
    end
    wr(13'h00d, 8'h01);
    repeat (10) @(negedge clk);
    cmp("inverted test word", 16'h03ff, {5'h00, dout});
    wr(13'h014, 8'h11);
    cmp("output disabled", 16'h0000, {15'h0000, doe});
    wr(13'h014, 8'h01);
    cmp("output enabled", 16'h0001, {15'h0000, doe});
    $display("done t_fmt");
  endtask

  // fixed words, held generators, then alternating and ramp words
  task automatic t_pat();
    logic [10:0] a;
    logic [10:0] b;
    for (int i = 0; i < 7; i++) begin
      wr(13'h00d, PM[i]);
      repeat (10) @(negedge clk);
      cmp("test word", {5'h00, PE[i]}, {5'h00, dout});
    end
    for (int m = 0; m < 3; m++) begin
      wr(13'h00d, m == 0 ? 8'h04 : (m == 1 ? 8'h07 : 8'h0f));
      repeat (10) @(negedge clk);
      a = dout;
      repeat (2) @(negedge clk);
      b = dout;
      if (m < 2)
        cmp("alternating pair", 16'h07ff, {5'h00, a ^ b});
      else
        cmp("ramp step", 16'h0001, {5'h00, b - a});
      // toggle words are the two full-scale extremes
      if (m == 1)
        cmp("toggle phase", 16'h0001, {15'h0000, a == 11'h000 || a == 11'h7ff});
    end
    $display("done t_pat");
  endtask

  // user word repeated, then sent once and followed by zeros
  task automatic t_user();
    wr(13'h019, 8'ha5);
    watch = 11'h0a5;
    wr(13'h00d, 8'h08);
    repeat (10) @(negedge clk);
    cmp("user word", 16'h00a5, {5'h00, dout});
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (40) @(negedge clk);
    cmp("user repeats", 16'h0001, {15'h0000, hits > 8'h10});
    wr(13'h00d, 8'h00);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    wr(13'h00d, 8'h88);
    repeat (20) @(negedge clk);
    cmp("single shot count", 16'h0001, {8'h00, hits});
    cmp("zeros after shot", 16'h0000, {5'h00, dout});
    $display("done t_user");
  endtask

  // main sequence
  initial begin
    rstn      = 1'b0;
    csb_n     = 1'b1;
    sclk      = 1'b0;
    sdi       = 1'b0;
    clr       = 1'b0;
    smp       = 11'h123;
    watch     = 11'h000;
    n_fail    = 0;
    tests_run = 0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    t_div();
    t_fmt();
    t_pat();
    t_user();
    give_verdict();
  end
endmodule
